// ===== common/pmc_pkg.sv
package pmc_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, word aligned)
	// ----------------------------------------------------------------
	localparam logic [31:0] POWER_MODE_SELECT_ADDR = 32'h4000_2400;
	localparam logic [31:0] MODE_UNLOCK_KEY_ADDR   = 32'h4000_2404;
	localparam logic [15:0] POWER_MODE_SELECT_RST  = 16'h0000;
	localparam logic [15:0] MODE_UNLOCK_KEY_RST    = 16'h0000;
	localparam logic [15:0] UNLOCK_KEY_FIRST       = 16'h4859;
	localparam logic [15:0] UNLOCK_KEY_SECOND      = 16'hf27b;
	localparam int          MODE_LSB               = 0;
	localparam int          MODE_W                 = 2;

	// ----------------------------------------------------------------
	// controller own registers
	// ----------------------------------------------------------------
	localparam logic [31:0] HOST_STATUS_ADDR = 32'h0000_0000;
	localparam logic [31:0] HOST_CMD_ADDR    = 32'h0000_0004;
	localparam logic [31:0] HOST_RDATA_ADDR  = 32'h0000_0008;
	localparam logic [31:0] HOST_WAKE_ADDR   = 32'h0000_000c;
	localparam int          CMD_ADDR_LSB     = 16;
	localparam int          CMD_WRITE_BIT    = 31;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		PMC_ACTIVE,
		PMC_CORE_DOZE,
		PMC_SYSTEM_DOZE,
		PMC_HIBERNATE
	} pmc_mode_e;

	typedef enum logic [1:0]
	{
		PMC_LOCKED,
		PMC_KEY1_SEEN,
		PMC_UNLOCKED
	} pmc_lock_e;

endpackage

// ===== common/pmc_if.sv
interface pmc_if;
	logic        req;
	logic        we;
	logic        addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        ack;
	logic        core_sleeping;
	logic        core_deep_sleep;
	logic        wake_event;
	logic        wake_restricted;
	logic        in_handler;
	logic        higher_prio_irq;

	modport dev
	(
		input  req, we, addr, wdata, core_sleeping, core_deep_sleep,
		input  wake_event, wake_restricted, in_handler, higher_prio_irq,
		output rdata, ack
	);
	modport host
	(
		output req, we, addr, wdata, core_sleeping, core_deep_sleep,
		output wake_event, wake_restricted, in_handler, higher_prio_irq,
		input  rdata, ack
	);
endinterface

// ===== src/pmc_key_lock.sv
module pmc_key_lock
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic wr_i,
	input  wire logic wr_key_i,
	input  wire logic [15:0] wdata_i,
	output logic      unlocked_o
);
	pmc_pkg::pmc_lock_e lock_r;

	assign unlocked_o = (lock_r == pmc_pkg::PMC_UNLOCKED);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			lock_r <= pmc_pkg::PMC_LOCKED;
		else if (wr_i)
		begin
			if (wr_key_i && wdata_i == pmc_pkg::UNLOCK_KEY_FIRST)
				lock_r <= pmc_pkg::PMC_KEY1_SEEN;
			else if (wr_key_i && lock_r == pmc_pkg::PMC_KEY1_SEEN
				&& wdata_i == pmc_pkg::UNLOCK_KEY_SECOND)
				lock_r <= pmc_pkg::PMC_UNLOCKED;
			else
				lock_r <= pmc_pkg::PMC_LOCKED;
		end
	end
endmodule

// ===== src/pmc_device.sv
module pmc_device
#(
	parameter int NUM_USER_CLK = 2
)
(
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    por_i,
	pmc_if.dev                           bus,
	input  wire logic                    debug_hold_set_i,
	input  wire logic [NUM_USER_CLK-1:0] user_clk_off_i,
	output logic                         core_clk_en_o,
	output logic                         sys_bus_clk_en_o,
	output logic                         periph_bus_clk_en_o,
	output logic                         irq_ctrl_clk_en_o,
	output logic                         logic_power_en_o,
	output logic                         retain_o,
	output logic [NUM_USER_CLK-1:0]      user_clk_en_o,
	output logic [1:0]                   active_mode_o
);
	logic [1:0]         mode_sel_r;
	logic [15:0]        key_r;
	logic               unlocked;
	logic               wr;
	logic               debug_hold_r;
	logic               handler_entry_r;
	pmc_pkg::pmc_mode_e cur_r;
	logic               wake;
	logic               sleep_seen_r;
	logic               sleep_entry;

	assign wr = bus.req && bus.we && !bus.ack;

	// --------------------------------------------------------------
	// key protection
	// --------------------------------------------------------------
	pmc_key_lock u_lock
	(
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.wr_i       (wr),
		.wr_key_i   (bus.addr),
		.wdata_i    (bus.wdata),
		.unlocked_o (unlocked)
	);

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	// zero after reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mode_sel_r <= pmc_pkg::POWER_MODE_SELECT_RST[1:0];
		else if (wr && !bus.addr && unlocked)
			mode_sel_r <= bus.wdata[pmc_pkg::MODE_LSB +: pmc_pkg::MODE_W];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			key_r <= pmc_pkg::MODE_UNLOCK_KEY_RST;
		else if (wr && bus.addr)
			key_r <= bus.wdata;
	end

	// one wait state answer, ack drops the cycle after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bus.ack <= 1'b0;
		else
			bus.ack <= bus.req && !bus.ack;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bus.rdata <= 16'h0000;
		else if (bus.req && !bus.ack)
			bus.rdata <= bus.addr ? key_r : {14'h0000, mode_sel_r};
	end

	// --------------------------------------------------------------
	// debug hold, power-on reset only
	// --------------------------------------------------------------
	// survives device reset
	always_ff @(posedge clk_i)
	begin
		if (por_i)
			debug_hold_r <= 1'b0;
		else if (debug_hold_set_i)
			debug_hold_r <= 1'b1;
	end

	// --------------------------------------------------------------
	// mode sequencing
	// --------------------------------------------------------------
	// entry is the rising edge of sleep
	// a core still asleep just after a wake must not re-enter
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sleep_seen_r <= 1'b0;
		else
			sleep_seen_r <= bus.core_sleeping;
	end

	assign sleep_entry = bus.core_sleeping && !sleep_seen_r;

	always_comb
	begin
		if (handler_entry_r)
			wake = bus.higher_prio_irq;
		else if (cur_r == pmc_pkg::PMC_HIBERNATE)
			wake = bus.wake_restricted;
		else
			wake = bus.wake_event;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cur_r           <= pmc_pkg::PMC_ACTIVE;
			handler_entry_r <= 1'b0;
		end
		else if (cur_r != pmc_pkg::PMC_ACTIVE)
		begin
			if (wake)
			begin
				cur_r           <= pmc_pkg::PMC_ACTIVE;
				handler_entry_r <= 1'b0;
			end
		end
		else if (sleep_entry && !debug_hold_r
			&& mode_sel_r != 2'b00
			&& (mode_sel_r != 2'b11 || bus.core_deep_sleep))
		begin
			cur_r           <= pmc_pkg::pmc_mode_e'(mode_sel_r);
			handler_entry_r <= bus.in_handler;
		end
	end

	// --------------------------------------------------------------
	// mode decode
	// --------------------------------------------------------------
	// bus clocks run in modes 0 and 1
	function automatic logic bus_clocks_on(input pmc_pkg::pmc_mode_e m);
		return m == pmc_pkg::PMC_ACTIVE
			|| m == pmc_pkg::PMC_CORE_DOZE;
	endfunction

	function automatic logic powered_on(input pmc_pkg::pmc_mode_e m);
		return m != pmc_pkg::PMC_HIBERNATE;
	endfunction

	// --------------------------------------------------------------
	// clock and power enables
	// --------------------------------------------------------------
	// core doze gates core
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			core_clk_en_o       <= 1'b1;
			sys_bus_clk_en_o    <= 1'b1;
			periph_bus_clk_en_o <= 1'b1;
			irq_ctrl_clk_en_o   <= 1'b1;
			logic_power_en_o    <= 1'b1;
			retain_o            <= 1'b0;
			user_clk_en_o       <= '0;
			active_mode_o       <= 2'b00;
		end
		else
		begin
			core_clk_en_o       <= cur_r == pmc_pkg::PMC_ACTIVE;
			sys_bus_clk_en_o    <= bus_clocks_on(cur_r);
			periph_bus_clk_en_o <= bus_clocks_on(cur_r);
			irq_ctrl_clk_en_o   <= powered_on(cur_r);
			logic_power_en_o    <= powered_on(cur_r);
			retain_o            <= !powered_on(cur_r);
			user_clk_en_o       <= bus_clocks_on(cur_r)
				? ~user_clk_off_i : '0;
			active_mode_o       <= cur_r;
		end
	end
endmodule

// ===== src/pmc_host.sv
module pmc_host
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	pmc_if.host              link,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        core_sleeping_i,
	input  wire logic        core_deep_sleep_i,
	input  wire logic        wake_event_i,
	input  wire logic        wake_restricted_i,
	input  wire logic        in_handler_i,
	input  wire logic        higher_prio_irq_i
);
	logic        busy_r;
	logic [15:0] rdata_r;
	logic        wb_req;

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	// core side levels pass through flops
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			link.core_sleeping   <= 1'b0;
			link.core_deep_sleep <= 1'b0;
			link.wake_event      <= 1'b0;
			link.wake_restricted <= 1'b0;
			link.in_handler      <= 1'b0;
			link.higher_prio_irq <= 1'b0;
		end
		else
		begin
			link.core_sleeping   <= core_sleeping_i;
			link.core_deep_sleep <= core_deep_sleep_i;
			link.wake_event      <= wake_event_i;
			link.wake_restricted <= wake_restricted_i;
			link.in_handler      <= in_handler_i;
			link.higher_prio_irq <= higher_prio_irq_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			link.req   <= 1'b0;
			link.we    <= 1'b0;
			link.addr  <= 1'b0;
			link.wdata <= 16'h0000;
			busy_r     <= 1'b0;
			rdata_r    <= 16'h0000;
		end
		else if (link.ack)
		begin
			link.req <= 1'b0;
			busy_r   <= 1'b0;
			if (!link.we)
				rdata_r <= link.rdata;
		end
		else if (wb_req && wb_we_i && wb_adr_i == pmc_pkg::HOST_CMD_ADDR
			&& !busy_r && wb_sel_i == 4'hf)
		begin
			link.req   <= 1'b1;
			busy_r     <= 1'b1;
			link.we    <= wb_dat_i[pmc_pkg::CMD_WRITE_BIT];
			link.addr  <= wb_dat_i[pmc_pkg::CMD_ADDR_LSB];
			link.wdata <= wb_dat_i[15:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i)
			begin
				if (wb_adr_i == pmc_pkg::HOST_STATUS_ADDR)
					wb_dat_o <= {31'h0000_0000, busy_r};
				else if (wb_adr_i == pmc_pkg::HOST_RDATA_ADDR)
					wb_dat_o <= {16'h0000, rdata_r};
				else
					wb_dat_o <= 32'h0000_0000;
			end
		end
	end
endmodule

// ===== bench/pmc_properties.sv
module pmc_properties
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic        addr,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] rdata,
	input  wire logic        ack
);
	logic [1:0] lk_r;
	logic [1:0] mode_r;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// --------------------------------------------------------
	// shadow of key state and last accepted mode
	// --------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			lk_r <= 2'h0;
		else if (ack && we && addr && wdata == pmc_pkg::UNLOCK_KEY_FIRST)
			lk_r <= 2'h1;
		else if (ack && we && addr && lk_r == 2'h1)
			lk_r <= (wdata == pmc_pkg::UNLOCK_KEY_SECOND) ? 2'h2 : 2'h0;
		else if (ack && we)
			lk_r <= 2'h0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mode_r <= 2'h0;
		else if (ack && we && !addr && lk_r == 2'h2)
			mode_r <= wdata[1:0];
	end

	sequence s_rd; ack && !we && !addr; endsequence
	property p_ack_next; req && !ack |=> ack; endproperty
	a_ack_next: assert property (p_ack_next) else $error("no ack");
	property p_ack_src; ack |-> $past(req) && !$past(ack); endproperty
	a_ack_src: assert property (p_ack_src) else $error("stray ack");
	property p_req_hold; req && !ack |=> req && $stable({we, addr, wdata});
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("req moved");
	property p_req_drop; ack |=> !req; endproperty
	a_req_drop: assert property (p_req_drop) else $error("req held");
	property p_rd_mode; s_rd |-> rdata[1:0] == mode_r; endproperty
	a_rd_mode: assert property (p_rd_mode) else $error("bad mode");
	property p_rd_rsv; s_rd |-> rdata[15:2] == 14'h0; endproperty
	a_rd_rsv: assert property (p_rd_rsv) else $error("rsv set");
	property p_rd_hold; !req |=> $stable(rdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
	property p_rst_zero; $fell(rst_i) |-> rdata == 16'h0 && !ack; endproperty
	a_rst_zero: assert property (p_rst_zero) else $error("not reset");

	c_unlocked: cover property (lk_r == 2'h2);
	c_mode_rd: cover property (s_rd);
	c_key_wr: cover property (ack && we && addr);
endmodule

// ===== bench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [15:0] K1 = pmc_pkg::UNLOCK_KEY_FIRST;
	localparam logic [15:0] K2 = pmc_pkg::UNLOCK_KEY_SECOND;
	// sleeping, deep, wake, restricted, handler, prio
	logic [5:0]  ctl = 6'h0;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        por_i = 1'b1;
	logic        dbg = 1'b0;
	logic [1:0]  uoff = 2'h0;
	logic        cyc = 1'b0;
	logic        wwe = 1'b0;
	logic [31:0] adr = 32'h0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rd;
	logic        ack;
	logic [31:0] r32;
	logic [15:0] q;
	logic [1:0]  m;
	wire logic [9:0] pins;
	int          miscompares = 0;
	int          tests_run = 0;

	pmc_if lnk();
	pmc_device #(.NUM_USER_CLK(2)) i_pmc_device
	(
		.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .bus(lnk),
		.debug_hold_set_i(dbg), .user_clk_off_i(uoff),
		.core_clk_en_o(pins[7]), .sys_bus_clk_en_o(pins[6]),
		.periph_bus_clk_en_o(pins[5]), .irq_ctrl_clk_en_o(pins[4]),
		.logic_power_en_o(pins[3]), .retain_o(pins[2]),
		.user_clk_en_o(pins[1:0]), .active_mode_o(pins[9:8])
	);
	pmc_host i_pmc_host
	(
		.clk_i(clk_i), .rst_i(rst_i), .link(lnk), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
		.core_sleeping_i(ctl[5]), .core_deep_sleep_i(ctl[4]),
		.wake_event_i(ctl[3]), .wake_restricted_i(ctl[2]),
		.in_handler_i(ctl[1]), .higher_prio_irq_i(ctl[0])
	);
	pmc_properties i_pmc_properties
	(
		.clk_i(clk_i), .rst_i(rst_i), .req(lnk.req), .we(lnk.we),
		.addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack)
	);

	always #2.5 clk_i = ~clk_i;

	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		wwe <= w;
		adr <= a;
		wd <= d;
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		r32 = rd;
		cyc <= 1'b0;
	endtask

	task automatic acc(input logic w, input logic r, input logic [15:0] d);
		wb(1'b1, pmc_pkg::HOST_CMD_ADDR, {w, 14'h0, r, d});
		do
			wb(1'b0, pmc_pkg::HOST_STATUS_ADDR, 32'h0);
		while (r32[0] !== 1'b0);
		wb(1'b0, pmc_pkg::HOST_RDATA_ADDR, 32'h0);
		q = r32[15:0];
	endtask

	task automatic unlock_mode(input logic [1:0] v);
		acc(1'b1, 1'b1, K1);
		acc(1'b1, 1'b1, K2);
		acc(1'b1, 1'b0, {14'h0, v});
	endtask

	function automatic logic [9:0] expo(input logic [1:0] v);
		logic lo;
		lo = v < 2'h2;
		expo = {v, v == 2'h0, lo, lo, v != 2'h3, v != 2'h3, v == 2'h3,
			lo ? ~uoff : 2'h0};
	endfunction

	task automatic chk_val(input string nm, input logic [15:0] e);
		tests_run++;
		if (q !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, q);
		end
	endtask

	task automatic chk_pins(input logic [1:0] v);
		repeat (6) @(posedge clk_i);
		tests_run++;
		if (pins !== expo(v))
		begin
			miscompares++;
			$display("Error pins expected %h seen %h", expo(v), pins);
		end
	endtask

	task automatic close_out;
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// --------------------------------------------------------
	// main sequence
	// --------------------------------------------------------
	initial
	begin
		void'($urandom(13588));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		acc(1'b0, 1'b0, 16'h0);
		chk_val("mode", pmc_pkg::POWER_MODE_SELECT_RST);
		acc(1'b0, 1'b1, 16'h0);
		chk_val("key", pmc_pkg::MODE_UNLOCK_KEY_RST);
		wb(1'b0, pmc_pkg::HOST_WAKE_ADDR, 32'h0);
		q = r32[15:0];
		chk_val("unmapped", 16'h0);
		ctl <= 6'h20;
		chk_pins(2'h0);
		for (int i = 0; i < 12; i++)
		begin
			m = (i < 4) ? 2'(i) : 2'($urandom_range(3));
			uoff <= 2'($urandom_range(3));
			ctl <= 6'h0;
			unlock_mode(m);
			acc(1'b0, 1'b0, 16'h0);
			chk_val("mode", {14'h0, m});
			chk_pins(2'h0);
			ctl <= 6'h30;
			chk_pins(m);
			ctl <= 6'h38;
			chk_pins((m == 2'h3) ? m : 2'h0);
			ctl <= 6'h1c;
			chk_pins(2'h0);
		end
		ctl <= 6'h0;
		unlock_mode(2'h1);
		acc(1'b1, 1'b1, K1);
		acc(1'b1, 1'b1, K2);
		acc(1'b1, 1'b1, 16'h0001);
		acc(1'b1, 1'b0, 16'h0002);
		acc(1'b0, 1'b0, 16'h0);
		chk_val("mode", 16'h0001);
		acc(1'b1, 1'b1, K2);
		acc(1'b1, 1'b1, K1);
		acc(1'b1, 1'b0, 16'h0002);
		acc(1'b0, 1'b0, 16'h0);
		chk_val("mode", 16'h0001);
		ctl <= 6'h22;
		chk_pins(2'h1);
		ctl <= 6'h0a;
		chk_pins(2'h1);
		ctl <= 6'h0b;
		chk_pins(2'h0);
		ctl <= 6'h0;
		unlock_mode(2'h3);
		ctl <= 6'h20;
		chk_pins(2'h0);
		ctl <= 6'h0;
		dbg <= 1'b1;
		@(posedge clk_i);
		dbg <= 1'b0;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		unlock_mode(2'h1);
		ctl <= 6'h20;
		chk_pins(2'h0);
		ctl <= 6'h0;
		por_i <= 1'b1;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		por_i <= 1'b0;
		rst_i <= 1'b0;
		unlock_mode(2'h1);
		ctl <= 6'h20;
		chk_pins(2'h1);
		close_out;
	end

	// run needs about a thousand cycles; allow forty times that
	initial
	begin
		#200000;
		miscompares++;
		close_out;
	end
endmodule
